// >>> src/fpp_pkg.sv
// Package for the five-port parallel I/O block: register map, field positions and pin bundles.
package fpp_pkg;

    // ========================================================================
    // Bus geometry
    localparam int unsigned ADDR_W = 14;
    localparam int unsigned DATA_W = 32;

    // ========================================================================
    // Register indices; the byte address is four times the index
    localparam logic [11:0] IDX_PORT_ZERO_DATA = 12'h000;
    localparam logic [11:0] IDX_PORT_ONE_DATA = 12'h001;
    localparam logic [11:0] IDX_PORT_TWO_DATA = 12'h002;
    localparam logic [11:0] IDX_PORT_THREE_DATA = 12'h003;
    localparam logic [11:0] IDX_PORT_TWO_DIRECTION = 12'h0F6;
    localparam logic [11:0] IDX_PORT_THREE_FUNCTION = 12'h0F7;
    localparam logic [11:0] IDX_PORT_ZERO_ONE_DIRECTION = 12'h0F8;
    localparam logic [11:0] IDX_SERIAL_CONTROL = 12'h0FA;
    localparam logic [11:0] IDX_PORT_DRIVER_CONFIG = 12'hF00;
    localparam logic [11:0] IDX_PORT_FOUR_DATA = 12'hF08;
    localparam logic [11:0] IDX_PORT_FOUR_DIRECTION = 12'hF09;

    // ========================================================================
    // Reset values
    localparam logic [7:0] RST_PORT_TWO_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_PORT_FOUR_DIRECTION = 8'hFF;
    localparam logic [7:0] RST_PORT_ZERO_ONE_DIRECTION = 8'h49;
    localparam logic [7:0] RST_PORT_DRIVER_CONFIG = 8'h0E;
    localparam logic [7:0] RST_PORT_THREE_FUNCTION = 8'h00;
    localparam logic [7:0] RST_SERIAL_CONTROL = 8'h00;
    localparam logic [7:0] RST_LATCH = 8'h00;

    // ========================================================================
    // Field positions
    localparam int unsigned BIT_P0_LOW_INPUT = 0;
    localparam int unsigned BIT_P1_INPUT = 3;
    localparam int unsigned BIT_P0_HIGH_INPUT = 6;
    localparam int unsigned BIT_P12_PUSH_PULL = 1;
    localparam int unsigned BIT_P0_PUSH_PULL = 2;
    localparam int unsigned BIT_TX_ENABLE = 7;
    localparam int unsigned BIT_TX_LINE = 7;
    localparam int unsigned OP_LSB = 8;

    // Write operation selected by write data bits 9:8 on a port data register.
    typedef enum logic [1:0] {
        FPP_OP_LOAD,
        FPP_OP_OR,
        FPP_OP_AND,
        FPP_OP_XOR
    } fpp_op_t;

    // ========================================================================
    // Pin bundles
    typedef struct packed {
        logic [7:0] portFour;
        logic [7:0] portThree;
        logic [7:0] portTwo;
        logic [7:0] portOne;
        logic [7:0] portZero;
    } fpp_pins_t;

    typedef struct packed {
        logic portFour;
        logic portTwo;
        logic portOne;
        logic portZeroHigh;
        logic portZeroLow;
    } fpp_pull_opt_t;

endpackage : fpp_pkg

// >>> src/fpp_port_io.sv
// Five-port parallel I/O block with an APB register slave.
//
// Contract
// - Five 8-bit ports, each its own data register.
// - Port zero direction chosen per nibble.
// - Port one direction chosen for whole byte.
// - Port two direction chosen per line.
// - Port four direction chosen per line.
// - Port three: low inputs, high outputs, fixed.
// - Pull-ups off on lines set as output.
// - Port reads return synchronised pin levels; port three high nibble returns the latch.
// - OR, AND, XOR combine pins, write latch.
// - Floating open-drain high line reads zero.
// - Port zero push-pull or open-drain by config bit two.
// - Reset or stop recovery makes port zero inputs.
// - Transmit enable routes transmitter onto port zero line seven.
// - Transmit reaches line seven only when upper nibble outputs.
// - Build-time port zero pull-ups per nibble, inputs only.
// - Ports one, two share one push-pull/open-drain choice.
// - Reset makes port one all inputs.
//
// The APB register port was left to the implementer.
module fpp_port_io
    import fpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stopRecovery,
    input wire logic serialTxData,
    input wire fpp_pull_opt_t pullOption,
    input wire fpp_pins_t pinIn,
    output fpp_pins_t pinOut,
    output fpp_pins_t pinOe,
    output fpp_pins_t pullEnable
);

    // ========================================================================
    // Pin synchronisers
    fpp_pins_t pinMeta_q;
    fpp_pins_t pinSync_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinMeta_q <= '0;
            pinSync_q <= '0;
        end else begin
            pinMeta_q <= pinIn;
            pinSync_q <= pinMeta_q;
        end
    end

    // ========================================================================
    // Bus decode
    logic [11:0] regIdx;
    logic accessPhase;
    logic doWrite;
    logic doRead;
    logic mapped;
    fpp_op_t writeOp;

    assign regIdx = paddr[13:2];
    assign accessPhase = psel && penable && !pready;
    assign doWrite = psel && penable && pready && pwrite && mapped;
    assign doRead = accessPhase && !pwrite;
    assign writeOp = fpp_op_t'(pwdata[OP_LSB+1:OP_LSB]);

    always_comb begin
        unique case (regIdx)
            IDX_PORT_ZERO_DATA, IDX_PORT_ONE_DATA, IDX_PORT_TWO_DATA, IDX_PORT_THREE_DATA,
            IDX_PORT_TWO_DIRECTION, IDX_PORT_THREE_FUNCTION, IDX_PORT_ZERO_ONE_DIRECTION,
            IDX_SERIAL_CONTROL, IDX_PORT_DRIVER_CONFIG, IDX_PORT_FOUR_DATA,
            IDX_PORT_FOUR_DIRECTION: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read-modify-write works on what the pins show, not on the latch, so an
    // open-drain line held low outside is written back low.
    function automatic logic [7:0] combine(input fpp_op_t op, input logic [7:0] pins,
                                           input logic [7:0] operand);
        logic [7:0] result;
        result = operand;
        unique case (op)
            FPP_OP_LOAD: result = operand;
            FPP_OP_OR: result = pins | operand;
            FPP_OP_AND: result = pins & operand;
            FPP_OP_XOR: result = pins ^ operand;
        endcase
        return result;
    endfunction

    // ========================================================================
    // Output latches
    fpp_pins_t latch_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            latch_q <= {5{RST_LATCH}};
        end else if (doWrite) begin
            unique case (regIdx)
                IDX_PORT_ZERO_DATA: latch_q.portZero <= combine(writeOp, pinSync_q.portZero, pwdata[7:0]);
                IDX_PORT_ONE_DATA: latch_q.portOne <= combine(writeOp, pinSync_q.portOne, pwdata[7:0]);
                IDX_PORT_TWO_DATA: latch_q.portTwo <= combine(writeOp, pinSync_q.portTwo, pwdata[7:0]);
                IDX_PORT_THREE_DATA: latch_q.portThree <= combine(writeOp, pinSync_q.portThree, pwdata[7:0]);
                IDX_PORT_FOUR_DATA: latch_q.portFour <= combine(writeOp, pinSync_q.portFour, pwdata[7:0]);
                default: latch_q <= latch_q;
            endcase
        end
    end

    // ========================================================================
    // Mode and configuration registers
    logic [7:0] portTwoDirection_q;
    logic [7:0] portFourDirection_q;
    logic [7:0] portZeroOneDirection_q;
    logic [7:0] portDriverConfig_q;
    logic [7:0] portThreeFunction_q;
    logic [7:0] serialControl_q;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            portTwoDirection_q <= RST_PORT_TWO_DIRECTION;
            portFourDirection_q <= RST_PORT_FOUR_DIRECTION;
            portDriverConfig_q <= RST_PORT_DRIVER_CONFIG;
            portThreeFunction_q <= RST_PORT_THREE_FUNCTION;
            serialControl_q <= RST_SERIAL_CONTROL;
        end else if (doWrite) begin
            unique case (regIdx)
                IDX_PORT_TWO_DIRECTION: portTwoDirection_q <= pwdata[7:0];
                IDX_PORT_FOUR_DIRECTION: portFourDirection_q <= pwdata[7:0];
                IDX_PORT_DRIVER_CONFIG: portDriverConfig_q <= pwdata[7:0];
                IDX_PORT_THREE_FUNCTION: portThreeFunction_q <= pwdata[7:0];
                IDX_SERIAL_CONTROL: serialControl_q <= pwdata[7:0];
                default: portTwoDirection_q <= portTwoDirection_q;
            endcase
        end
    end

    // Stop recovery only returns port zero to input; port one keeps its mode.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            portZeroOneDirection_q <= RST_PORT_ZERO_ONE_DIRECTION;
        end else if (stopRecovery) begin
            portZeroOneDirection_q[BIT_P0_LOW_INPUT] <= 1'b1;
            portZeroOneDirection_q[BIT_P0_HIGH_INPUT] <= 1'b1;
        end else if (doWrite && regIdx == IDX_PORT_ZERO_ONE_DIRECTION) begin
            portZeroOneDirection_q <= pwdata[7:0];
        end
    end

    // ========================================================================
    // Direction and driver decode; a one means the line drives
    fpp_pins_t isOutput;
    logic zeroPushPull;
    logic sharedPushPull;
    logic txActive;

    assign zeroPushPull = portDriverConfig_q[BIT_P0_PUSH_PULL];
    assign sharedPushPull = portDriverConfig_q[BIT_P12_PUSH_PULL];
    assign txActive = serialControl_q[BIT_TX_ENABLE];

    always_comb begin
        isOutput.portZero = {{4{~portZeroOneDirection_q[BIT_P0_HIGH_INPUT]}},
                             {4{~portZeroOneDirection_q[BIT_P0_LOW_INPUT]}}};
        isOutput.portOne = {8{~portZeroOneDirection_q[BIT_P1_INPUT]}};
        isOutput.portTwo = ~portTwoDirection_q;
        isOutput.portThree = 8'hF0;
        isOutput.portFour = ~portFourDirection_q;
    end

    // ========================================================================
    // Pin drive, registered so every pad signal leaves a flip-flop
    fpp_pins_t pinOut_d;
    fpp_pins_t pinOe_d;
    fpp_pins_t pullEnable_d;
    logic [7:0] zeroValue;

    always_comb begin
        zeroValue = latch_q.portZero;
        if (txActive) begin
            zeroValue[BIT_TX_LINE] = serialTxData;
        end
        // An open-drain line only pulls low; a one leaves the pin floating.
        pinOut_d.portZero = zeroPushPull ? zeroValue : 8'h00;
        pinOe_d.portZero = isOutput.portZero & (zeroPushPull ? 8'hFF : ~zeroValue);
        pinOut_d.portOne = sharedPushPull ? latch_q.portOne : 8'h00;
        pinOe_d.portOne = isOutput.portOne & (sharedPushPull ? 8'hFF : ~latch_q.portOne);
        pinOut_d.portTwo = sharedPushPull ? latch_q.portTwo : 8'h00;
        pinOe_d.portTwo = isOutput.portTwo & (sharedPushPull ? 8'hFF : ~latch_q.portTwo);
        pinOut_d.portThree = {latch_q.portThree[7:4], 4'h0};
        pinOe_d.portThree = isOutput.portThree;
        // Port four has no global drive choice here, so it is push-pull.
        pinOut_d.portFour = latch_q.portFour;
        pinOe_d.portFour = isOutput.portFour;
        pullEnable_d.portZero = {{4{pullOption.portZeroHigh}}, {4{pullOption.portZeroLow}}}
                                & ~isOutput.portZero;
        pullEnable_d.portOne = {8{pullOption.portOne}} & ~isOutput.portOne;
        pullEnable_d.portTwo = {8{pullOption.portTwo}} & ~isOutput.portTwo;
        pullEnable_d.portThree = 8'h00;
        pullEnable_d.portFour = {8{pullOption.portFour}} & ~isOutput.portFour;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pinOut <= '0;
            pinOe <= '0;
            pullEnable <= '0;
        end else begin
            pinOut <= pinOut_d;
            pinOe <= pinOe_d;
            pullEnable <= pullEnable_d;
        end
    end

    // ========================================================================
    // Read data
    logic [7:0] readByte;

    always_comb begin
        unique case (regIdx)
            IDX_PORT_ZERO_DATA: readByte = pinSync_q.portZero;
            IDX_PORT_ONE_DATA: readByte = pinSync_q.portOne;
            IDX_PORT_TWO_DATA: readByte = pinSync_q.portTwo;
            IDX_PORT_THREE_DATA: readByte = {latch_q.portThree[7:4], pinSync_q.portThree[3:0]};
            IDX_PORT_FOUR_DATA: readByte = pinSync_q.portFour;
            IDX_PORT_TWO_DIRECTION: readByte = portTwoDirection_q;
            IDX_PORT_FOUR_DIRECTION: readByte = portFourDirection_q;
            IDX_PORT_ZERO_ONE_DIRECTION: readByte = portZeroOneDirection_q;
            IDX_PORT_DRIVER_CONFIG: readByte = portDriverConfig_q;
            IDX_PORT_THREE_FUNCTION: readByte = portThreeFunction_q;
            IDX_SERIAL_CONTROL: readByte = serialControl_q;
            default: readByte = 8'h00;
        endcase
    end

    // ========================================================================
    // APB answer: one wait state, then pready for a single cycle
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= accessPhase;
            pslverr <= accessPhase && !mapped;
            if (doRead) begin
                prdata <= {24'h000000, readByte};
            end
        end
    end

endmodule // fpp_port_io

// >>> test/fpp_pin_model.sv
// External circuit model that resolves the pad levels seen by the port block.
module fpp_pin_model
    import fpp_pkg::*;
(
    input wire fpp_pins_t pinOut,
    input wire fpp_pins_t pinOe,
    input wire fpp_pins_t pullEnable,
    input wire fpp_pins_t extVal,
    input wire fpp_pins_t extEn,
    output fpp_pins_t pinIn
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================================
    // Pad resolution
    // An undriven line without pull-up settles low, so a released open-drain line reads zero.
    always_comb begin
        pinIn = fpp_pins_t'((pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn & pullEnable));
    end
endmodule // fpp_pin_model

// >>> test/fpp_port_io_properties.sv
// Concurrent checks on the ports of the parallel I/O block.
module fpp_port_io_properties
    import fpp_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stopRecovery,
    input wire fpp_pins_t pinOe,
    input wire fpp_pins_t pullEnable
);
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================================
    // Helpers
    logic [1:0] releaseAge_q;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            releaseAge_q <= 2'h0;
        end else if (releaseAge_q != 2'h3) begin
            releaseAge_q <= releaseAge_q + 2'h1;
        end
    end
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable;
    endsequence
    // ========================================================================
    // Properties
    a_ready_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready) else $error("wait state count");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready longer than one cycle");
    a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
    a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
    a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    a_err_data_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
    a_pull_off_out: assert property ((pinOe & pullEnable) == 40'h0 && pullEnable.portThree == 8'h00)
        else $error("pull-up on driven line");
    a_p3_fixed_dir: assert property (releaseAge_q == 2'h3 |-> pinOe.portThree == 8'hF0) else $error("port three dir");
    a_stop_input: assert property (stopRecovery |-> ##2 pinOe.portZero == 8'h00) else $error("stop recovery");
endmodule // fpp_port_io_properties

bind fpp_port_io fpp_port_io_properties fpp_port_io_properties_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stopRecovery(stopRecovery), .pinOe(pinOe), .pullEnable(pullEnable));

// >>> test/test_five_port_parallel_io.sv
// Self-checking bench for the five-port parallel I/O block.
module test_five_port_parallel_io;
    timeunit 1ns;
    timeprecision 1ps;
    import fpp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic stopRecovery = 1'b0;
    logic serialTxData = 1'b0;
    fpp_pull_opt_t pullOption = '0;
    fpp_pins_t pinIn, pinOut, pinOe, pullEnable;
    fpp_pins_t extVal = '0;
    fpp_pins_t extEn = '0;
    logic [31:0] seed = 32'h40;
    logic [31:0] rdData, m, v, x, p;
    logic errSeen;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    fpp_port_io fpp_port_io_i (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .stopRecovery(stopRecovery), .serialTxData(serialTxData), .pullOption(pullOption), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .pullEnable(pullEnable));
    fpp_pin_model fpp_pin_model_i (.pinOut(pinOut), .pinOe(pinOe), .pullEnable(pullEnable), .extVal(extVal),
        .extEn(extEn), .pinIn(pinIn));
    always #4 clk_sys = ~clk_sys;
    // ========================================================================
    // Helpers
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function logic [7:0] expMix(input logic [7:0] latch, input logic [7:0] pins, input logic [7:0] dir);
        return (latch & ~dir) | (pins & dir);
    endfunction
    function logic [7:0] expOp(input logic [1:0] op, input logic [7:0] pins, input logic [7:0] o);
        case (op)
            2'h1: return pins | o;
            2'h2: return pins & o;
            2'h3: return pins ^ o;
            default: return o;
        endcase
    endfunction
    task test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] expv);
        n_compared++;
        if (seen !== expv) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, expv);
        end
    endtask
    // The request is held until pready is sampled high; only the timeout ends the wait.
    task apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rdData = prdata;
        errSeen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdChk(input logic [11:0] idx, input logic [31:0] expv);
        apb(1'b0, idx, 32'h0);
        chk(rdData, expv);
    endtask
    task settle();
        repeat (3) @(posedge clk_sys);
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            test_done();
        end
    end
    // ========================================================================
    // Scenarios
    initial begin
        rdData = rnd();
        // Pull-ups forced on for ports two, four and upper port zero so the pull checks can fail.
        pullOption <= rdData[4:0] | 5'h1A;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rdChk(IDX_PORT_TWO_DIRECTION, 32'hFF);
        rdChk(IDX_PORT_FOUR_DIRECTION, 32'hFF);
        rdChk(IDX_PORT_ZERO_ONE_DIRECTION, RST_PORT_ZERO_ONE_DIRECTION);
        rdChk(IDX_PORT_DRIVER_CONFIG, RST_PORT_DRIVER_CONFIG);
        chk(pinOe.portZero, 8'h00);
        chk(pinOe.portOne, 8'h00);
        apb(1'b0, 12'h004, 32'h0);
        chk(errSeen, 1'b1);
        v = rnd();
        apb(1'b1, IDX_PORT_THREE_FUNCTION, v & 32'hFF);
        rdChk(IDX_PORT_THREE_FUNCTION, v[7:0]);
        for (int k = 0; k < 6; k++) begin
            m = (k < 2) ? 32'h0 : (k < 4) ? 32'hFF : rnd();
            v = rnd();
            x = rnd();
            apb(1'b1, IDX_PORT_TWO_DIRECTION, m & 32'hFF);
            apb(1'b1, IDX_PORT_FOUR_DIRECTION, m & 32'hFF);
            apb(1'b1, IDX_PORT_TWO_DATA, v & 32'hFF);
            apb(1'b1, IDX_PORT_FOUR_DATA, v & 32'hFF);
            extEn.portTwo <= m[7:0];
            extEn.portFour <= m[7:0];
            extVal.portTwo <= x[7:0];
            extVal.portFour <= x[7:0];
            settle();
            chk(pinOe.portTwo, {~m[7:0]});
            chk(pinOe.portFour, {~m[7:0]});
            chk(pullEnable.portTwo, m[7:0] & {8{pullOption.portTwo}});
            chk(pullEnable.portFour, m[7:0] & {8{pullOption.portFour}});
            rdChk(IDX_PORT_TWO_DATA, expMix(v[7:0], x[7:0], m[7:0]));
            rdChk(IDX_PORT_FOUR_DATA, expMix(v[7:0], x[7:0], m[7:0]));
        end
        // Input lines make pins differ from the latch, so a latch-based merge shows up.
        apb(1'b1, IDX_PORT_TWO_DIRECTION, 32'h0F);
        extEn.portTwo <= 8'h0F;
        p = expMix(v[7:0], x[7:0], 8'h0F);
        for (int k = 1; k < 4; k++) begin
            m = rnd();
            apb(1'b1, IDX_PORT_TWO_DATA, {22'h0, k[1:0], m[7:0]});
            settle();
            p = expMix(expOp(k[1:0], p[7:0], m[7:0]), x[7:0], 8'h0F);
            rdChk(IDX_PORT_TWO_DATA, p);
        end
        apb(1'b1, IDX_PORT_DRIVER_CONFIG, 32'h0C);
        settle();
        chk(pinOe.portTwo, {~p[7:4], 4'h0});
        chk(pinOut.portTwo, 8'h00);
        rdChk(IDX_PORT_TWO_DATA, {4'h0, x[3:0]});
        x = rnd();
        extEn.portZero <= 8'hF0;
        extVal.portZero <= x[7:0];
        apb(1'b1, IDX_PORT_DRIVER_CONFIG, 32'h0A);
        apb(1'b1, IDX_PORT_ZERO_ONE_DIRECTION, 32'h48);
        apb(1'b1, IDX_PORT_ZERO_DATA, 32'h05);
        settle();
        chk(pinOe.portZero, 8'h0A);
        chk(pinOut.portZero, 8'h00);
        rdChk(IDX_PORT_ZERO_DATA, {x[7:4], 4'h0});
        apb(1'b1, IDX_PORT_DRIVER_CONFIG, 32'h0E);
        settle();
        chk(pinOe.portZero, 8'h0F);
        rdChk(IDX_PORT_ZERO_DATA, {x[7:4], 4'h5});
        chk(pullEnable.portZero, {{4{pullOption.portZeroHigh}}, 4'h0});
        chk(pullEnable.portOne, {8{pullOption.portOne}});
        apb(1'b1, IDX_PORT_ZERO_ONE_DIRECTION, 32'h40);
        settle();
        chk(pinOe.portOne, 8'hFF);
        chk(pullEnable.portOne, 8'h00);
        apb(1'b1, IDX_SERIAL_CONTROL, 32'h80);
        apb(1'b1, IDX_PORT_ZERO_ONE_DIRECTION, 32'h08);
        for (int k = 0; k < 4; k++) begin
            x = rnd();
            serialTxData <= x[3];
            settle();
            chk(pinOut.portZero[7], x[3]);
            chk(pinOe.portZero[7], 1'b1);
        end
        apb(1'b1, IDX_PORT_ZERO_ONE_DIRECTION, 32'h48);
        settle();
        chk(pinOe.portZero[7], 1'b0);
        apb(1'b1, IDX_PORT_ZERO_ONE_DIRECTION, 32'h08);
        stopRecovery <= 1'b1;
        @(posedge clk_sys);
        stopRecovery <= 1'b0;
        settle();
        chk(pinOe.portZero, 8'h00);
        apb(1'b0, IDX_PORT_ZERO_ONE_DIRECTION, 32'h0);
        chk(rdData & 32'h41, 32'h41);
        x = rnd();
        extEn.portThree <= 8'h0F;
        extVal.portThree <= x[7:0];
        apb(1'b1, IDX_PORT_THREE_DATA, 32'hA5);
        settle();
        chk(pinOut.portThree[7:4], 4'hA);
        rdChk(IDX_PORT_THREE_DATA, {4'hA, x[3:0]});
        test_done();
    end
endmodule // test_five_port_parallel_io
